// ==== rtl/ldo_regulator_control_regs.sv ====
// Control and status register bank for three linear regulators
//
// Function
// - Control bit 7 turns the regulator on when 1, off when 0.
// - Control bit 6 discharges the output while the regulator is shut down.
// - Control bit 5 selects low-power mode when 1, normal mode when 0.
// - Control bits 4..2 pick the turn-on delay used when starting.
// - Control bit 1 allows fault interrupts when 1, suppresses when 0.
// - Control bit 0 reads 1 only while output is above power-good.
// - Voltage bits 5..0 hold the level code; bits 7..6 read-only zero.
// - Reset output held low for nominal 64 ms, within 56.3 to 72.8 ms.
// - Button, interrupt and reset outputs are open-drain, only pulled low.
`timescale 1ns/10ps
module ldo_regulator_control_regs
    import ldo_regs_pkg::*;
#(
    parameter longint RESET_CYC = RESET_DELAY_CYC,
    parameter int     STEP_CYC  = DELAY_STEP_CYC
) (
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_b_i,
    input  wire logic                       ce_i,
    input  wire logic [ADDR_W-1:0]          reg_addr_i,
    input  wire logic [DATA_W-1:0]          reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic      [DATA_W-1:0]          reg_rdata_o,
    output logic                            reg_ack_o,
    input  wire logic [NUM_LDO-1:0]         pgood_i,
    input  wire logic                       button_pressed_i,
    output logic      [NUM_LDO-1:0]         ldo_enable_o,
    output logic      [NUM_LDO-1:0]         shutdown_discharge_o,
    output logic      [NUM_LDO-1:0]         low_quiescent_mode_o,
    output logic      [NUM_LDO*LEVEL_W-1:0] output_level_code_o,
    output logic                            irq_out_n_o,
    output logic                            irq_out_n_oe_o,
    output logic                            reset_out_n_o,
    output logic                            reset_out_n_oe_o,
    output logic                            button_state_n_o,
    output logic                            button_state_n_oe_o
);
    localparam int RST_W = $clog2(RESET_CYC + 1);

    initial begin
        if (RESET_CYC < 1 || STEP_CYC < 1) begin
            $error("Delay counts must be at least one cycle");
        end
    end

    logic [NUM_LDO-1:0][BIT_ON:BIT_ALLOW] ctrl_r;
    logic [NUM_LDO-1:0][LEVEL_W-1:0] level_r;
    logic [NUM_LDO-1:0]              pgood_prev_r;
    logic [NUM_LDO-1:0]              fault_r;
    logic [NUM_LDO-1:0]              run_w;
    logic [NUM_LDO:0][DATA_W-1:0]    rd_acc_w;
    logic [NUM_LDO-1:0]              irq_req_w;
    logic [RST_W-1:0]                rst_cnt_r;

    // ****************************************
    // Per-regulator registers
    // ****************************************
    assign rd_acc_w[0] = RD_NONE;

    generate
        for (genvar i = 0; i < NUM_LDO; i++) begin : g_ldo
            wire ctrl_hit = (reg_addr_i == CTRL_OFS[i]);
            wire volt_hit = (reg_addr_i == VOLT_OFS[i]);
            wire ctrl_wr  = reg_wr_i && ctrl_hit;
            wire volt_wr  = reg_wr_i && volt_hit;
            wire ctrl_rd  = reg_rd_i && ctrl_hit;
            // Lost power-good while running counts as a fault
            wire fall     = pgood_prev_r[i] && !pgood_i[i] && run_w[i];
            wire [DATA_W-1:0] ctrl_view = {ctrl_r[i], pgood_i[i]};
            // Upper two bits read as zero
            wire [DATA_W-1:0] volt_view = {{(DATA_W-LEVEL_W){1'b0}}, level_r[i]};

            assign rd_acc_w[i+1] = rd_acc_w[i]
                                 | (ctrl_hit ? ctrl_view : RD_NONE)
                                 | (volt_hit ? volt_view : RD_NONE);
            assign irq_req_w[i] = fault_r[i] && ctrl_r[i][BIT_ALLOW];

            // ****************************************
            // Register storage
            // ****************************************
            always_ff @(posedge clk_sys_i) begin
                if (!rst_b_i) begin
                    ctrl_r[i] <= CTRL_RST[BIT_ON:BIT_ALLOW];
                end else if (ce_i && ctrl_wr) begin
                    // Bits 7..1 writable, bit 0 write ignored
                    ctrl_r[i] <= reg_wdata_i[BIT_ON:BIT_ALLOW];
                end
            end

            always_ff @(posedge clk_sys_i) begin
                if (!rst_b_i) begin
                    level_r[i] <= LEVEL_RST;
                end else if (ce_i && volt_wr) begin
                    // Only the level code is stored
                    level_r[i] <= reg_wdata_i[LEVEL_W-1:0];
                end
            end

            // ****************************************
            // Fault capture
            // ****************************************
            always_ff @(posedge clk_sys_i) begin
                if (!rst_b_i) begin
                    pgood_prev_r[i] <= 1'b0;
                    fault_r[i]      <= 1'b0;
                end else if (ce_i) begin
                    pgood_prev_r[i] <= pgood_i[i];
                    fault_r[i]      <= fall || (fault_r[i] && !ctrl_rd);
                end
            end

            ldo_start_delay #(
                .STEP_CYC    (STEP_CYC)
            ) u_start (
                .clk_sys_i   (clk_sys_i),
                .rst_b_i     (rst_b_i),
                .ce_i        (ce_i),
                .on_i        (ctrl_r[i][BIT_ON]),
                .delay_sel_i (ctrl_r[i][DELAY_HI:DELAY_LO]),
                .run_o       (run_w[i])
            );

            assign ldo_enable_o[i] = run_w[i];
            assign output_level_code_o[i*LEVEL_W +: LEVEL_W] = level_r[i];
            assign low_quiescent_mode_o[i] = ctrl_r[i][BIT_LOW_QUIESCENT_MODE];

            always_ff @(posedge clk_sys_i) begin
                if (!rst_b_i) begin
                    shutdown_discharge_o[i] <= 1'b0;
                end else if (ce_i) begin
                    shutdown_discharge_o[i] <= ctrl_r[i][BIT_DIS] && !run_w[i];
                end
            end
        end
    endgenerate

    // ****************************************
    // Register port answer
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= RD_NONE;
            reg_ack_o   <= 1'b0;
        end else if (ce_i) begin
            reg_rdata_o <= reg_rd_i ? rd_acc_w[NUM_LDO] : reg_rdata_o;
            reg_ack_o   <= reg_rd_i || reg_wr_i;
        end
    end

    // ****************************************
    // Reset output timer
    // ****************************************
    // Counts from reset release; wide counter is the price of one clock
    wire rst_done = (rst_cnt_r >= RST_W'(RESET_CYC));

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rst_cnt_r <= '0;
        end else if (ce_i && !rst_done) begin
            // Hold reset low for the full delay
            rst_cnt_r <= rst_cnt_r + RST_W'(1);
        end
    end

    // ****************************************
    // Open-drain status pins
    // ****************************************
    // Reset pin pulled until the timer ends
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            reset_out_n_oe_o <= 1'b1;
        end else if (ce_i) begin
            reset_out_n_oe_o <= !rst_done;
        end
    end

    // Any allowed fault pulls the line
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            irq_out_n_oe_o <= 1'b0;
        end else if (ce_i) begin
            irq_out_n_oe_o <= |irq_req_w;
        end
    end

    // Button level passed on one cycle late
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            button_state_n_oe_o <= 1'b0;
        end else if (ce_i) begin
            button_state_n_oe_o <= button_pressed_i;
        end
    end

    // Pin levels stay low, enables do the work
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            irq_out_n_o      <= 1'b0;
            reset_out_n_o    <= 1'b0;
            button_state_n_o <= 1'b0;
        end else if (ce_i) begin
            irq_out_n_o      <= 1'b0;
            reset_out_n_o    <= 1'b0;
            button_state_n_o <= 1'b0;
        end
    end

endmodule : ldo_regulator_control_regs

// ==== rtl/ldo_regs_pkg.sv ====
// Constants shared by the regulator control register bank
package ldo_regs_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int              NUM_LDO   = 3;
    localparam int              ADDR_W    = 8;
    localparam int              DATA_W    = 8;
    localparam int              LEVEL_W   = 6;
    localparam int              DELAY_W   = 3;
    // Index 0 = ldo_b, 1 = ldo_c, 2 = ldo_d
    localparam logic [2:0][7:0] VOLT_OFS  = {8'h64, 8'h60, 8'h54};
    localparam logic [2:0][7:0] CTRL_OFS  = {8'h65, 8'h61, 8'h55};

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int              BIT_ON    = 7;
    localparam int              BIT_DIS   = 6;
    localparam int              BIT_LOW_QUIESCENT_MODE = 5;
    localparam int              DELAY_HI  = 4;
    localparam int              DELAY_LO  = 2;
    localparam int              BIT_ALLOW = 1;
    localparam int              BIT_OK    = 0;
    localparam logic [7:0]      CTRL_RST  = 8'h00;
    localparam logic [5:0]      LEVEL_RST = 6'h00;
    localparam logic [7:0]      RD_NONE   = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam longint          CLK_HZ           = 20_000_000;
    localparam longint          RESET_DELAY_US   = 64_000;
    localparam longint          RESET_MIN_US     = 56_300;
    localparam longint          RESET_MAX_US     = 72_800;
    localparam longint          RESET_DELAY_CYC  = RESET_DELAY_US * CLK_HZ / 1_000_000;
    localparam int              DELAY_STEP_CYC   = 20;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } start_state_t;

endpackage : ldo_regs_pkg

// ==== rtl/ldo_start_delay.sv ====
// Turn-on delay sequencer for one regulator
`timescale 1ns/10ps
module ldo_start_delay
    import ldo_regs_pkg::*;
#(
    parameter int STEP_CYC = DELAY_STEP_CYC
) (
    input  wire logic               clk_sys_i,
    input  wire logic               rst_b_i,
    input  wire logic               ce_i,
    input  wire logic               on_i,
    input  wire logic [DELAY_W-1:0] delay_sel_i,
    output logic                    run_o
);
    localparam int CNT_W = $clog2(7 * STEP_CYC + 2);

    initial begin
        if (STEP_CYC < 1) begin
            $error("STEP_CYC must be at least one");
        end
    end

    start_state_t     state_r;
    start_state_t     state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    wire  [CNT_W-1:0] load_val = CNT_W'(delay_sel_i * STEP_CYC);

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            ST_OFF: begin
                if (on_i) begin
                    cnt_nxt   = load_val;
                    state_nxt = (load_val == '0) ? ST_RUN : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!on_i) begin
                    state_nxt = ST_OFF;
                end else if (cnt_r <= CNT_W'(1)) begin
                    state_nxt = ST_RUN;
                end else begin
                    cnt_nxt = cnt_r - CNT_W'(1);
                end
            end
            ST_RUN: begin
                if (!on_i) begin
                    state_nxt = ST_OFF;
                end
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            state_r <= ST_OFF;
            cnt_r   <= '0;
            run_o   <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            run_o   <= (state_nxt == ST_RUN);
        end
    end

endmodule : ldo_start_delay

// ==== verif/ldo_regs_checker_assertions.sv ====
// Assertion checker for the regulator register bank
`timescale 1ns/10ps
module ldo_regs_checker
    import ldo_regs_pkg::*;
#(
    parameter longint RESET_CYC = RESET_DELAY_CYC
) (
    input wire logic               clk_sys_i,
    input wire logic               rst_b_i,
    input wire logic               ce_i,
    input wire logic [ADDR_W-1:0]  reg_addr_i,
    input wire logic [DATA_W-1:0]  reg_wdata_i,
    input wire logic               reg_wr_i,
    input wire logic               reg_rd_i,
    input wire logic [DATA_W-1:0]  reg_rdata_o,
    input wire logic               reg_ack_o,
    input wire logic [NUM_LDO-1:0] pgood_i,
    input wire logic [NUM_LDO-1:0] ldo_enable_o,
    input wire logic [NUM_LDO-1:0] shutdown_discharge_o,
    input wire logic               irq_out_n_o,
    input wire logic               irq_out_n_oe_o,
    input wire logic               reset_out_n_o,
    input wire logic               reset_out_n_oe_o,
    input wire logic               button_state_n_o
);
    // ****************************************
    // Properties
    // ****************************************
    longint hold_cnt_r;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // Counts ce cycles since release, stops one past the hold length
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) hold_cnt_r <= 0;
        else if (ce_i && hold_cnt_r <= RESET_CYC) hold_cnt_r <= hold_cnt_r + 1;
    end
    sequence s_start_b;
        ce_i && reg_wr_i && reg_addr_i == CTRL_OFS[0] && reg_wdata_i[BIT_ON]
            && reg_wdata_i[DELAY_HI:DELAY_LO] == 3'b000 && !ldo_enable_o[0];
    endsequence
    sequence s_irq_cause;
        $past(reg_rd_i) || $past(reg_rd_i, 2) || $past(reg_rd_i, 3) || $past(reg_wr_i)
            || $past(reg_wr_i, 2) || $past(reg_wr_i, 3);
    endsequence
    a_ack_one_cycle: assert property (ce_i && (reg_wr_i || reg_rd_i) |=> reg_ack_o)
        else $error("no acknowledge one cycle after request");
    a_start_no_delay: assert property (s_start_b |=> ##1 ldo_enable_o[0])
        else $error("regulator not running two cycles after start");
    a_ok_bit_read: assert property (ce_i && reg_rd_i && reg_addr_i == 8'h55
        |=> reg_rdata_o[0] == $past(pgood_i[0]))
        else $error("status bit does not follow power good");
    a_volt_reserved: assert property (ce_i && reg_rd_i
        && reg_addr_i inside {8'h54, 8'h60, 8'h64} |=> reg_rdata_o[7:6] == 2'b00)
        else $error("reserved voltage bits not zero");
    a_discharge_off_run: assert property (
        (shutdown_discharge_o & ldo_enable_o & $past(ldo_enable_o)) == 3'b000)
        else $error("discharge while regulator running");
    a_open_drain_low: assert property (!irq_out_n_o && !reset_out_n_o && !button_state_n_o)
        else $error("open-drain output driven high");
    a_reset_hold_len: assert property (reset_out_n_oe_o == (hold_cnt_r <= RESET_CYC))
        else $error("reset output hold length wrong");
    a_irq_drop_cause: assert property ($fell(irq_out_n_oe_o) |-> s_irq_cause)
        else $error("interrupt dropped without register access");
endmodule : ldo_regs_checker

bind ldo_regulator_control_regs ldo_regs_checker #(.RESET_CYC(RESET_CYC)) chk (.*);

// ==== verif/ldo_host_model.sv ====
// Host model driving the register port
`timescale 1ns/10ps
module ldo_host_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       ack_i,
    output logic      [7:0] addr_o = 8'h00,
    output logic      [7:0] wdata_o = 8'h00,
    output logic            wr_o = 1'b0,
    output logic            rd_o = 1'b0
);
    // ****************************************
    // Register transfer
    // ****************************************
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
        @(posedge clk_sys_i);
        wr_o    <= w;
        rd_o    <= !w;
        addr_o  <= a;
        wdata_o <= d;
        @(posedge clk_sys_i);
        wr_o    <= 1'b0;
        rd_o    <= 1'b0;
        // Released lines show the inverse, never the last value
        addr_o  <= ~a;
        wdata_o <= ~d;
        ok = 1'b0;
        // Strobe is a one-cycle pulse; answer taken at the acking edge
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge clk_sys_i);
            ok = (ack_i === 1'b1);
        end
        q = rdata_i;
    endtask : xfer
endmodule : ldo_host_model

// ==== verif/tb_ldo_regulator_control_regs.sv ====
// Self-checking bench for the regulator register bank
`timescale 1ns/10ps
module tb_ldo_regulator_control_regs
    import ldo_regs_pkg::*;
;
    // ****************************************
    // Bench
    // ****************************************
    localparam longint RC = 50;
    localparam int     SC = 2;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, btn = 1'b0, ce = 1'b1, wr, rd, ack, ok;
    logic [2:0] pgood = 3'b000, en, dis, lowq, od_oe, od_lv;
    logic [7:0] addr, wdata, rdata, q;
    logic [17:0] level;
    int err_count = 0, comparisons = 0;
    ldo_regulator_control_regs #(.RESET_CYC(RC), .STEP_CYC(SC)) uut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .reg_ack_o(ack), .pgood_i(pgood), .button_pressed_i(btn), .ldo_enable_o(en),
        .shutdown_discharge_o(dis), .low_quiescent_mode_o(lowq), .output_level_code_o(level),
        .irq_out_n_o(od_lv[0]), .irq_out_n_oe_o(od_oe[0]), .reset_out_n_o(od_lv[1]),
        .reset_out_n_oe_o(od_oe[1]), .button_state_n_o(od_lv[2]), .button_state_n_oe_o(od_oe[2]));
    ldo_host_model host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .ack_i(ack), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    initial forever #25 clk_sys_i = ~clk_sys_i;
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wait_for(ref logic [2:0] s, input int i, input logic v, output int n);
        for (n = 0; n < 200 && s[i] !== v; n++) @(negedge clk_sys_i);
        if (n == 200) begin
            err_count++;
            tally_and_finish();
        end
    endtask : wait_for
    // Read compares against d, write stores d
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        host.xfer(w, a, d, q, ok);
        if (!ok) begin
            err_count++;
            tally_and_finish();
        end
        if (!w) check("read data", {24'h0, d}, {24'h0, q});
    endtask : acc
    task automatic t_reset();
        int n;
        wait_for(od_oe, 1, 1'b0, n);
        // Spread is allowed, so two cycles of slack
        check("reset hold", 1, n >= RC && n <= RC + 2);
        check("od levels", 3'b000, od_lv);
        for (int i = 0; i < 3; i++) begin
            acc(1'b0, VOLT_OFS[i], 8'h00);
            acc(1'b0, CTRL_OFS[i], 8'h00);
        end
        $display("test reset done");
    endtask : t_reset
    task automatic t_fields();
        pgood <= 3'b111;
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, VOLT_OFS[i], 8'hff);
            acc(1'b0, VOLT_OFS[i], 8'h3f);
            acc(1'b1, CTRL_OFS[i], 8'h7e);
            acc(1'b0, CTRL_OFS[i], 8'h7f);
        end
        check("discharge", 3'b111, dis);
        check("low power", 3'b111, lowq);
        check("enable", 3'b000, en);
        check("level", 18'h3ffff, level);
        acc(1'b1, 8'h56, 8'hff);
        acc(1'b0, 8'h56, 8'h00);
        $display("test fields done");
    endtask : t_fields
    task automatic t_delay();
        int n;
        for (int s = 7; s >= 0; s -= 7) begin
            acc(1'b1, 8'h55, 8'h42);
            repeat (2) @(negedge clk_sys_i);
            check("off", 2'b01, {en[0], dis[0]});
            acc(1'b1, 8'h55, {3'b110, 3'(s), 2'b10});
            wait_for(en, 0, 1'b1, n);
            check("delay", 1, n >= s * SC && n <= s * SC + 2);
            @(negedge clk_sys_i);
            check("no discharge", 1'b0, dis[0]);
        end
        $display("test delay done");
    endtask : t_delay
    task automatic t_irq();
        int n;
        @(posedge clk_sys_i) pgood[0] <= 1'b0;
        wait_for(od_oe, 0, 1'b1, n);
        check("irq rise", 1, n <= 4);
        acc(1'b0, 8'h55, 8'hc2);
        wait_for(od_oe, 0, 1'b0, n);
        check("irq clear", 1, n <= 4);
        acc(1'b1, 8'h55, 8'h80);
        @(posedge clk_sys_i) pgood[0] <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        pgood[0] <= 1'b0;
        repeat (6) @(negedge clk_sys_i);
        check("irq masked", 1'b0, od_oe[0]);
        acc(1'b1, 8'h55, 8'h82);
        wait_for(od_oe, 0, 1'b1, n);
        check("irq allowed", 1, n <= 4);
        acc(1'b0, 8'h55, 8'h82);
        wait_for(od_oe, 0, 1'b0, n);
        $display("test irq done");
    endtask : t_irq
    task automatic t_button();
        int n;
        @(posedge clk_sys_i) btn <= 1'b1;
        wait_for(od_oe, 2, 1'b1, n);
        check("button", 1, n <= 3);
        check("button level", 1'b0, od_lv[2]);
        @(posedge clk_sys_i) btn <= 1'b0;
        wait_for(od_oe, 2, 1'b0, n);
        $display("test button done");
    endtask : t_button
    task automatic t_freeze();
        int n;
        acc(1'b1, CTRL_OFS[1], 8'h9c);
        @(posedge clk_sys_i) ce <= 1'b0;
        repeat (30) @(negedge clk_sys_i);
        check("frozen enable", 1'b0, en[1]);
        @(posedge clk_sys_i) ce <= 1'b1;
        wait_for(en, 1, 1'b1, n);
        check("resume delay", 1, n >= 7 * SC - 2 && n <= 7 * SC);
        $display("test freeze done");
    endtask : t_freeze
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_fields();
        t_delay();
        t_irq();
        t_button();
        t_freeze();
        tally_and_finish();
    end
endmodule : tb_ldo_regulator_control_regs
